// ==== rtl/obc_cfg.svh ====
// constants for the operand bypass and coprocessor sequencing block
`ifndef OBC_CFG_SVH
`define OBC_CFG_SVH
`define OBC_DATA_W 32
`define OBC_IDX_W 5
`define OBC_ZERO_REG 5'h00
`define OBC_RST_IDX 5'h00
`define OBC_RST_DATA 32'h0000_0000
`define OBC_BC2_MIN_SLIP 2'h2
`define OBC_BC2_CNT_MAX 2'h3
`endif

// ==== rtl/obc_pkg.sv ====
// types shared by the bypass mux and the pipeline control
`include "obc_cfg.svh"
package obc_pkg;
    typedef logic [`OBC_DATA_W-1:0] obc_word_t;
    typedef logic [`OBC_IDX_W-1:0] obc_idx_t;
    typedef enum logic [1:0] {
        OBC_FWD_RF = 2'b00,
        OBC_FWD_W = 2'b01,
        OBC_FWD_A = 2'b10,
        OBC_FWD_M = 2'b11
    } obc_fwd_sel_t;
endpackage : obc_pkg

// ==== rtl/obc_fwd_mux.sv ====
// one operand forwarding multiplexer with register file write-through
`include "obc_cfg.svh"
module obc_fwd_mux (
    input wire obc_pkg::obc_idx_t src,
    input wire obc_pkg::obc_word_t rf_rdata,
    input wire logic m_wr,
    input wire obc_pkg::obc_idx_t m_dst,
    input wire obc_pkg::obc_word_t m_data,
    input wire logic a_wr,
    input wire obc_pkg::obc_idx_t a_dst,
    input wire obc_pkg::obc_word_t a_data,
    input wire logic w_wr,
    input wire obc_pkg::obc_idx_t w_dst,
    input wire obc_pkg::obc_word_t w_data,
    output obc_pkg::obc_word_t op_data,
    output obc_pkg::obc_fwd_sel_t sel
);
    import obc_pkg::*;

    // register zero is constant, so it never matches a producer
    wire logic src_live = (src != `OBC_ZERO_REG);
    wire logic m_hit = m_wr && (m_dst == src) && src_live;
    wire logic a_hit = a_wr && (a_dst == src) && src_live;
    wire logic w_hit = w_wr && (w_dst == src) && src_live;

    // youngest producer wins: memory stage, then align, then writeback
    assign sel = m_hit ? OBC_FWD_M :
                 a_hit ? OBC_FWD_A :
                 w_hit ? OBC_FWD_W : OBC_FWD_RF;

    // writeback data passes straight to the read port in the same cycle
    assign op_data = (sel == OBC_FWD_M) ? m_data :
                     (sel == OBC_FWD_A) ? a_data :
                     (sel == OBC_FWD_W) ? w_data : rf_rdata;
endmodule // obc_fwd_mux

// ==== rtl/obc_pipe_ctrl.sv ====
// operand forwarding, interlock slips and second coprocessor sequencing
`include "obc_cfg.svh"
// What this block does
// - operands read early in execute; results usable early in memory stage
// - each operand has a mux fed from memory and align stage results
// - register file passes writeback data straight to both read ports
// - each operand chooses its forwarding source independently
// - consumer right after a load slips one cycle in execute
// - consumers one or two behind a load get data via align forwarding
// - moves from mult or system coprocessor forward from align, slip one cycle
// - coprocessor unusable: no interface transaction, raise unusable exception
// - coprocessor instruction driven on instruction bus during execute
// - valid signalled in memory stage; coprocessor returns captured in registers
// - missing returns hold align stage and all earlier stages
// - data to the coprocessor is driven during the align stage
// - completion signalled in writeback; returned data written to register file
// - all branches resolved in execute; no prediction
// - coprocessor branch drives instruction and valid while in execute; its completion is signalled in writeback
// - coprocessor branch slips at least two cycles, more if condition late
// - a held stage holds all earlier ones; later stages get bubbles
module obc_pipe_ctrl (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic cop2_usable_bit,
    input wire logic id_valid,
    input wire obc_pkg::obc_idx_t id_first_source_reg,
    input wire obc_pkg::obc_idx_t id_second_source_reg,
    input wire logic id_use_first,
    input wire logic id_use_second,
    input wire obc_pkg::obc_idx_t id_dst,
    input wire logic id_dst_wr,
    input wire logic id_late_result,
    input wire logic id_is_cop2,
    input wire logic id_is_bc2,
    input wire logic id_core_to_cop2,
    input wire obc_pkg::obc_word_t id_instr,
    input wire obc_pkg::obc_word_t rf_rdata1,
    input wire obc_pkg::obc_word_t rf_rdata2,
    input wire obc_pkg::obc_word_t m_alu_result,
    input wire obc_pkg::obc_word_t a_result,
    input wire logic cp_ret_valid,
    input wire obc_pkg::obc_word_t cp_ret_data,
    input wire logic cp_bc_valid,
    input wire logic cp_bc_cond,
    output logic i_advance,
    output logic m_advance,
    output logic a_advance,
    output obc_pkg::obc_idx_t rf_raddr1,
    output obc_pkg::obc_idx_t rf_raddr2,
    output obc_pkg::obc_word_t op1_data,
    output obc_pkg::obc_word_t op2_data,
    output obc_pkg::obc_fwd_sel_t op1_sel,
    output obc_pkg::obc_fwd_sel_t op2_sel,
    output logic rf_we,
    output obc_pkg::obc_idx_t rf_waddr,
    output obc_pkg::obc_word_t rf_wdata,
    output obc_pkg::obc_word_t cop2_instr,
    output logic cop2_instr_en,
    output logic cop2_valid,
    output obc_pkg::obc_word_t cop2_wdata,
    output logic cop2_wdata_en,
    output logic cop2_commit,
    output logic cop2_unusable_exc,
    output logic br_bc2_resolved,
    output logic br_bc2_taken
);
    import obc_pkg::*;

    // execute stage state
    logic e_valid_reg, e_dst_wr_reg, e_late_reg, e_cop_reg, e_bc2_reg, e_to_cop_reg;
    logic [1:0] e_use_reg;
    obc_idx_t e_src_reg [1:0];
    obc_idx_t e_dst_reg;
    obc_word_t e_instr_reg;
    // memory, align and writeback stage state
    logic m_valid_reg, m_wr_reg, m_late_reg, m_cop_reg, m_commit_reg, m_to_cop_reg;
    logic a_valid_reg, a_wr_reg, a_cop_reg, a_commit_reg, a_to_cop_reg;
    logic w_valid_reg, w_wr_reg, w_commit_reg;
    obc_idx_t m_dst_reg, a_dst_reg, w_dst_reg;
    obc_word_t m_wdata_reg, wdata_reg, w_data_reg;
    // coprocessor input registers and return bookkeeping
    logic ret_cap_reg, ret_pend_reg, bc_cap_reg, bc_cond_reg, bc_got_reg;
    obc_word_t ret_data_reg;
    logic [1:0] bc_cnt_reg;
    obc_word_t fwd_data [1:0];
    obc_fwd_sel_t fwd_sel [1:0];

    // coprocessor usability gate on the execute instruction
    wire logic e_cop_ok = e_valid_reg && e_cop_reg && cop2_usable_bit;
    wire logic e_bc2_ok = e_cop_ok && e_bc2_reg;
    wire logic e_cop_mem = e_cop_ok && !e_bc2_reg;

    // align waits on returns; the captured flag covers late answers
    wire logic ret_ok = ret_cap_reg || ret_pend_reg;
    wire logic a_hold = a_valid_reg && a_cop_reg && !ret_ok;
    wire logic m_hold = a_hold;

    // load or move-from result still in memory stage: not yet forwardable
    // forwarding it from memory would hand the consumer stale alu data
    wire logic src0_hit = e_use_reg[0] && (e_src_reg[0] == m_dst_reg);
    wire logic src1_hit = e_use_reg[1] && (e_src_reg[1] == m_dst_reg);
    wire logic late_live = m_valid_reg && m_wr_reg && m_late_reg && (m_dst_reg != `OBC_ZERO_REG);
    wire logic late_hazard = e_valid_reg && late_live && (src0_hit || src1_hit);

    // coprocessor branch needs the minimum slip and a returned condition
    wire logic bc_ready = (bc_cnt_reg >= `OBC_BC2_MIN_SLIP) && (bc_cap_reg || bc_got_reg);
    wire logic bc2_wait = e_bc2_ok && !bc_ready;
    wire logic e_hold = m_hold || late_hazard || bc2_wait;
    wire logic e_to_m = e_valid_reg && !e_hold;
    wire logic a_consume = a_valid_reg && a_cop_reg && !a_hold;

    // stage advance outputs toward fetch and the datapath
    // writeback never holds, so a held align stage always drains into a bubble
    assign i_advance = !e_hold;
    assign m_advance = !m_hold;
    assign a_advance = !a_hold;

    // operands addressed from the execute stage registers
    assign rf_raddr1 = e_src_reg[0];
    assign rf_raddr2 = e_src_reg[1];

    // one independent forwarding mux per operand
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_opnd
            obc_fwd_mux obc_fwd_mux_inst (
                .src(e_src_reg[gi]),
                .rf_rdata((gi == 0) ? rf_rdata1 : rf_rdata2),
                .m_wr(m_valid_reg && m_wr_reg && !m_late_reg),
                .m_dst(m_dst_reg),
                .m_data(m_alu_result),
                .a_wr(a_valid_reg && a_wr_reg),
                .a_dst(a_dst_reg),
                .a_data(a_result),
                .w_wr(rf_we),
                .w_dst(w_dst_reg),
                .w_data(w_data_reg),
                .op_data(fwd_data[gi]),
                .sel(fwd_sel[gi])
            );
        end
    endgenerate
    assign op1_data = fwd_data[0];
    assign op2_data = fwd_data[1];
    assign op1_sel = fwd_sel[0];
    assign op2_sel = fwd_sel[1];

    // coprocessor handshake: bus in execute, valid in memory stage, branch valid in execute
    assign cop2_instr = e_instr_reg;
    assign cop2_instr_en = e_cop_ok;
    assign cop2_valid = (m_valid_reg && m_cop_reg && !m_hold) ||
                        (e_bc2_ok && (bc_cnt_reg == 2'h1));
    assign cop2_unusable_exc = e_valid_reg && e_cop_reg && !cop2_usable_bit;
    assign cop2_wdata = wdata_reg;
    assign cop2_wdata_en = a_valid_reg && a_to_cop_reg;
    assign cop2_commit = w_valid_reg && w_commit_reg;
    assign br_bc2_resolved = e_bc2_ok && bc_ready && !e_hold;
    assign br_bc2_taken = bc_cond_reg;
    assign rf_we = w_valid_reg && w_wr_reg;
    assign rf_waddr = w_dst_reg;
    assign rf_wdata = w_data_reg;

    // execute stage load; a held stage keeps its instruction
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            e_valid_reg <= 1'b0;
            {e_dst_wr_reg, e_late_reg, e_cop_reg, e_bc2_reg, e_to_cop_reg} <= 5'h00;
            e_use_reg <= 2'h0;
            e_src_reg[0] <= `OBC_RST_IDX;
            e_src_reg[1] <= `OBC_RST_IDX;
            e_dst_reg <= `OBC_RST_IDX;
            e_instr_reg <= `OBC_RST_DATA;
        end else if (clk_en && !e_hold) begin
            e_valid_reg <= id_valid;
            {e_dst_wr_reg, e_late_reg} <= {id_dst_wr, id_late_result};
            {e_cop_reg, e_bc2_reg, e_to_cop_reg} <= {id_is_cop2, id_is_bc2, id_core_to_cop2};
            e_use_reg <= {id_use_second, id_use_first};
            e_src_reg[0] <= id_first_source_reg;
            e_src_reg[1] <= id_second_source_reg;
            e_dst_reg <= id_dst;
            e_instr_reg <= id_instr;
        end
    end

    // memory stage: takes execute or a bubble unless held
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {m_valid_reg, m_wr_reg, m_late_reg} <= 3'h0;
            {m_cop_reg, m_commit_reg, m_to_cop_reg} <= 3'h0;
            m_dst_reg <= `OBC_RST_IDX;
            m_wdata_reg <= `OBC_RST_DATA;
        end else if (clk_en && !m_hold) begin
            m_valid_reg <= e_to_m;
            {m_wr_reg, m_late_reg} <= {e_dst_wr_reg, e_late_reg};
            {m_cop_reg, m_commit_reg} <= {e_cop_mem, e_cop_ok};
            m_to_cop_reg <= e_cop_mem && e_to_cop_reg;
            m_dst_reg <= e_dst_reg;
            m_wdata_reg <= fwd_data[1];
        end
    end

    // align stage: holds while coprocessor returns are missing
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {a_valid_reg, a_wr_reg, a_cop_reg, a_commit_reg, a_to_cop_reg} <= 5'h00;
            a_dst_reg <= `OBC_RST_IDX;
            wdata_reg <= `OBC_RST_DATA;
        end else if (clk_en && !a_hold) begin
            a_valid_reg <= m_valid_reg;
            {a_wr_reg, a_cop_reg} <= {m_wr_reg, m_cop_reg};
            {a_commit_reg, a_to_cop_reg} <= {m_commit_reg, m_to_cop_reg};
            a_dst_reg <= m_dst_reg;
            wdata_reg <= m_wdata_reg;
        end
    end

    // writeback: bubble behind a held align stage
    // limitation: returned data is the last capture, one return per instruction
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {w_valid_reg, w_wr_reg, w_commit_reg} <= 3'h0;
            w_dst_reg <= `OBC_RST_IDX;
            w_data_reg <= `OBC_RST_DATA;
        end else if (clk_en) begin
            w_valid_reg <= a_valid_reg && !a_hold;
            {w_wr_reg, w_commit_reg} <= {a_wr_reg, a_commit_reg};
            w_dst_reg <= a_dst_reg;
            w_data_reg <= a_cop_reg ? ret_data_reg : a_result;
        end
    end

    // coprocessor outputs land in input registers before any use
    // one cycle of latency traded for a clean path from the coprocessor
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {ret_cap_reg, bc_cap_reg} <= 2'h0;
            ret_data_reg <= `OBC_RST_DATA;
        end else if (clk_en) begin
            ret_cap_reg <= cp_ret_valid;
            bc_cap_reg <= cp_bc_valid;
            if (cp_ret_valid) begin
                ret_data_reg <= cp_ret_data;
            end
        end
    end

    // late return is kept until the align instruction moves on
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ret_pend_reg <= 1'b0;
        end else if (clk_en) begin
            ret_pend_reg <= a_consume ? 1'b0 : (ret_pend_reg || ret_cap_reg);
        end
    end

    // branch slip counter and sticky condition, restarted on each new execute load
    // the counter saturates so a slow condition cannot wrap it back to zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bc_cnt_reg <= 2'h0;
            {bc_got_reg, bc_cond_reg} <= 2'h0;
        end else if (clk_en) begin
            if (!e_hold) begin
                bc_cnt_reg <= 2'h0;
                bc_got_reg <= 1'b0;
            end else if (e_bc2_ok) begin
                if (bc_cnt_reg != `OBC_BC2_CNT_MAX) begin
                    bc_cnt_reg <= bc_cnt_reg + 2'h1;
                end
                bc_got_reg <= bc_got_reg || bc_cap_reg;
            end
            if (cp_bc_valid) begin
                bc_cond_reg <= cp_bc_cond;
            end
        end
    end

    // checks on the control behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    load_slip_bubble_a: assert property (
        (clk_en && late_hazard && !m_hold) |=> !m_valid_reg && $stable(e_instr_reg))
        else $error("no bubble after a late result hazard");

    // forwarding checks
    mem_priority_a: assert property (
        (m_valid_reg && m_wr_reg && !m_late_reg && a_valid_reg && a_wr_reg &&
         m_dst_reg == a_dst_reg && e_src_reg[0] == m_dst_reg && m_dst_reg != 5'h00)
        |-> op1_data == m_alu_result)
        else $error("older align result chosen over memory stage");
    align_fwd_a: assert property (
        (fwd_sel[1] == OBC_FWD_A) |-> op2_data == a_result && a_dst_reg == e_src_reg[1])
        else $error("align forwarding carries wrong data");
    wb_through_a: assert property (
        (fwd_sel[0] == OBC_FWD_W) |-> op1_data == w_data_reg && rf_we)
        else $error("writeback data not passed to read port");
    late_no_mem_a: assert property (
        late_live |-> fwd_sel[0] != OBC_FWD_M && fwd_sel[1] != OBC_FWD_M)
        else $error("late result forwarded from memory stage");

    // coprocessor handshake checks
    unusable_block_a: assert property (
        (e_valid_reg && e_cop_reg && !cop2_usable_bit) |-> !cop2_instr_en && cop2_unusable_exc)
        else $error("transaction started on unusable coprocessor");
    valid_in_mem_a: assert property (
        (clk_en && e_to_m && e_cop_mem && !m_hold) |=> m_cop_reg && (cop2_valid || m_hold))
        else $error("coprocessor valid missing in memory stage");
    ret_hold_a: assert property (
        (clk_en && a_valid_reg && a_cop_reg && !ret_ok) |->
        !i_advance ##1 a_valid_reg && a_cop_reg)
        else $error("align left without coprocessor return");
    wdata_align_a: assert property (
        (clk_en && !a_hold && m_valid_reg && m_to_cop_reg) |=>
        cop2_wdata_en && cop2_wdata == $past(m_wdata_reg))
        else $error("outgoing coprocessor data not in align stage");
    commit_wb_a: assert property (
        (clk_en && a_consume && a_commit_reg) |=>
        cop2_commit && (!w_wr_reg || rf_wdata == $past(ret_data_reg)))
        else $error("completion or returned data missing in writeback");
    bc2_min_slip_a: assert property (
        br_bc2_resolved |-> $past(e_hold) && $past(e_hold, 2))
        else $error("coprocessor branch resolved before two slips");

    // stage hold and bubble checks
    exec_hold_keep_a: assert property (
        (clk_en && e_hold) |=> $stable(e_instr_reg) && $stable(e_valid_reg))
        else $error("held execute stage lost its instruction");
    mem_hold_a: assert property (
        (clk_en && a_hold) |=> $stable(m_valid_reg) && $stable(m_dst_reg))
        else $error("memory stage moved behind a held align stage");
    wb_bubble_a: assert property (
        (clk_en && a_hold) |=> !w_valid_reg)
        else $error("writeback took an instruction from a held align stage");

    // main scenarios worth seeing at least once
    cov_load_slip: cover property (clk_en && late_hazard ##1 e_valid_reg && !late_hazard);
    cov_wb_fwd: cover property (fwd_sel[0] == OBC_FWD_W);
    cov_bc2: cover property (br_bc2_resolved && bc_cnt_reg == 2'h3);
    cov_ret_wait: cover property (a_hold [*2] ##1 !a_hold);
    cov_split_fwd: cover property (fwd_sel[0] == OBC_FWD_A && fwd_sel[1] == OBC_FWD_M);
endmodule // obc_pipe_ctrl

// ==== verif/obc_cop2_model.sv ====
// behavioural second coprocessor answering each validated instruction unless an answer is already pending
module obc_cop2_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] delay,
    input wire obc_pkg::obc_word_t ret_word,
    input wire logic cop2_valid,
    output logic cp_ret_valid,
    output obc_pkg::obc_word_t cp_ret_data,
    output logic cp_bc_valid,
    output logic cp_bc_cond
);
    timeunit 1ns;
    timeprecision 100ps;
    import obc_pkg::*;
    logic pend_reg;
    logic [1:0] cnt_reg;
    wire logic ans_now;
    // late answer counter; a pending answer ignores new pulses
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pend_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end else if (pend_reg) begin
            pend_reg <= (cnt_reg != delay);
            cnt_reg <= cnt_reg + 2'h1;
        end else if (cop2_valid && delay != 2'h0) begin
            pend_reg <= 1'b1;
            cnt_reg <= 2'h1;
        end
    end
    // zero delay answers in the validating cycle itself
    assign ans_now = (cop2_valid && delay == 2'h0) || (pend_reg && cnt_reg == delay);
    assign cp_ret_valid = ans_now;
    assign cp_bc_valid = ans_now;
    // released lines show the inverse, never a stale match
    assign cp_ret_data = ans_now ? ret_word : ~ret_word;
    assign cp_bc_cond = ans_now ? ret_word[0] : ~ret_word[0];
endmodule // obc_cop2_model

// ==== verif/tb_obc_pipe_ctrl.sv ====
// self-checking bench for forwarding, slips and coprocessor sequencing
module tb_obc_pipe_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    import obc_pkg::*;
    typedef struct {obc_idx_t da, db, a, b; logic lt; obc_fwd_sel_t e1, e2;} obc_row_t;
    localparam obc_word_t M_RES = 32'h1111_0000;
    localparam obc_word_t A_RES = 32'h2222_0000;
    logic ref_clk = 1'b0, rst = 1'b1, usable = 1'b1, id_valid = 1'b0, dst_wr = 1'b0;
    logic late = 1'b0, is_cop = 1'b0, is_bc = 1'b0;
    logic [1:0] delay = 2'h0;
    obc_idx_t s1 = 5'h00, s2 = 5'h00, dst = 5'h00, ra1, ra2, waddr;
    obc_word_t instr = 32'h4a00_1234, ret_word = 32'h0000_0000, rd1, rd2, op1, op2, wdata;
    obc_word_t c_instr, c_wdata, cp_data;
    obc_fwd_sel_t sel1, sel2;
    logic i_adv, m_adv, a_adv, rf_we, instr_en, cv, wd_en, commit, exc, resolved, taken;
    logic cp_ret_valid, cp_bc_valid, cp_bc_cond;
    int failures = 0, check_count = 0, cycles = 0, n;
    obc_row_t rows [5];
    // register file read ports: value tagged by its index
    assign rd1 = {8'hc1, 19'h0, ra1};
    assign rd2 = {8'hc1, 19'h0, ra2};
    obc_pipe_ctrl obc_pipe_ctrl_inst (
        .ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .cop2_usable_bit(usable),
        .id_valid(id_valid), .id_first_source_reg(s1), .id_second_source_reg(s2),
        .id_use_first(1'b1), .id_use_second(1'b1), .id_dst(dst), .id_dst_wr(dst_wr),
        .id_late_result(late), .id_is_cop2(is_cop), .id_is_bc2(is_bc),
        .id_core_to_cop2(is_cop), .id_instr(instr), .rf_rdata1(rd1), .rf_rdata2(rd2),
        .m_alu_result(M_RES), .a_result(A_RES), .cp_ret_valid(cp_ret_valid),
        .cp_ret_data(cp_data), .cp_bc_valid(cp_bc_valid), .cp_bc_cond(cp_bc_cond),
        .i_advance(i_adv), .m_advance(m_adv), .a_advance(a_adv), .rf_raddr1(ra1),
        .rf_raddr2(ra2), .op1_data(op1), .op2_data(op2), .op1_sel(sel1), .op2_sel(sel2),
        .rf_we(rf_we), .rf_waddr(waddr), .rf_wdata(wdata), .cop2_instr(c_instr),
        .cop2_instr_en(instr_en), .cop2_valid(cv), .cop2_wdata(c_wdata),
        .cop2_wdata_en(wd_en), .cop2_commit(commit), .cop2_unusable_exc(exc),
        .br_bc2_resolved(resolved), .br_bc2_taken(taken)
    );
    obc_cop2_model obc_cop2_model_inst (
        .ref_clk(ref_clk), .rst(rst), .delay(delay), .ret_word(ret_word), .cop2_valid(cv),
        .cp_ret_valid(cp_ret_valid), .cp_ret_data(cp_data), .cp_bc_valid(cp_bc_valid),
        .cp_bc_cond(cp_bc_cond)
    );
    // clock and hang guard
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            complete_run();
        end
    end
    task automatic chk(input obc_word_t seen, input obc_word_t exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step();
        @(negedge ref_clk);
        #1;
    endtask
    // present one instruction and wait until the execute stage takes it
    task automatic issue(input obc_idx_t a, input obc_idx_t b, input obc_idx_t d,
                         input logic lt, input logic cp, input logic bc);
        int k;
        id_valid = 1'b1;
        s1 = a;
        s2 = b;
        dst = d;
        dst_wr = (d != 5'h00);
        late = lt;
        is_cop = cp;
        is_bc = bc;
        k = 0;
        #1;
        while (i_adv !== 1'b1 && k < 20) begin
            step();
            k++;
        end
        step();
    endtask
    task automatic idle();
        id_valid = 1'b0;
        is_cop = 1'b0;
        is_bc = 1'b0;
    endtask
    function automatic obc_word_t exp_data(input obc_fwd_sel_t e, input obc_idx_t r);
        if (e == OBC_FWD_M) return M_RES;
        if (e == OBC_FWD_A) return A_RES;
        return {8'hc1, 19'h0, r};
    endfunction
    task automatic complete_run();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        rows = '{'{3, 4, 4, 3, 0, OBC_FWD_M, OBC_FWD_A}, '{5, 5, 5, 6, 0, OBC_FWD_M, OBC_FWD_RF},
                 '{0, 0, 0, 0, 0, OBC_FWD_RF, OBC_FWD_RF}, '{7, 8, 7, 9, 1, OBC_FWD_A, OBC_FWD_RF},
                 '{6, 2, 1, 2, 0, OBC_FWD_RF, OBC_FWD_M}};
        repeat (12) @(posedge ref_clk);
        #1;
        chk(32'(i_adv), 32'h1);
        chk(32'(cv), 32'h0);
        chk(32'(rf_we), 32'h0);
        @(negedge ref_clk);
        rst = 1'b0;
        #1;
        $display("test reset done");
        // two producers then a consumer, each row isolated by bubbles
        foreach (rows[k]) begin
            issue(5'h00, 5'h00, rows[k].da, rows[k].lt, 1'b0, 1'b0);
            issue(5'h00, 5'h00, rows[k].db, 1'b0, 1'b0, 1'b0);
            issue(rows[k].a, rows[k].b, 5'h00, 1'b0, 1'b0, 1'b0);
            idle();
            chk(32'(ra1), 32'(rows[k].a));
            chk(32'(sel1), 32'(rows[k].e1));
            chk(32'(sel2), 32'(rows[k].e2));
            chk(op1, exp_data(rows[k].e1, rows[k].a));
            chk(op2, exp_data(rows[k].e2, rows[k].b));
            repeat (4) step();
        end
        $display("test forwarding rows done");
        // late producer directly followed by its consumer
        issue(5'h00, 5'h00, 5'h09, 1'b1, 1'b0, 1'b0);
        issue(5'h09, 5'h00, 5'h00, 1'b0, 1'b0, 1'b0);
        idle();
        chk(32'(i_adv), 32'h0);
        chk(32'(m_adv), 32'h1);
        step();
        chk(32'(sel1), 32'(OBC_FWD_A));
        chk(op1, A_RES);
        repeat (4) step();
        $display("test late slip done");
        // producer three ahead reaches its consumer through the write-through path
        issue(5'h00, 5'h00, 5'h0d, 1'b0, 1'b0, 1'b0);
        issue(5'h00, 5'h00, 5'h00, 1'b0, 1'b0, 1'b0);
        issue(5'h00, 5'h00, 5'h00, 1'b0, 1'b0, 1'b0);
        issue(5'h0d, 5'h00, 5'h00, 1'b0, 1'b0, 1'b0);
        idle();
        chk(32'(sel1), 32'(OBC_FWD_W));
        chk(op1, A_RES);
        chk(32'(waddr), 32'h0000_000d);
        repeat (4) step();
        $display("test write-through done");
        // coprocessor instruction answered on time
        ret_word = 32'h3c5a_7e19;
        issue(5'h01, 5'h00, 5'h0a, 1'b0, 1'b1, 1'b0);
        idle();
        chk(32'(instr_en), 32'h1);
        chk(c_instr, 32'h4a00_1234);
        chk(32'(exc), 32'h0);
        step();
        chk(32'(cv), 32'h1);
        step();
        chk(32'(wd_en), 32'h1);
        chk(c_wdata, 32'hc100_0000);
        chk(32'(a_adv), 32'h1);
        step();
        chk(32'(commit), 32'h1);
        chk(32'(rf_we), 32'h1);
        chk(32'(waddr), 32'h0000_000a);
        chk(wdata, 32'h3c5a_7e19);
        repeat (3) step();
        // return two cycles late holds the align stage and all behind it
        delay = 2'h2;
        issue(5'h01, 5'h00, 5'h0b, 1'b0, 1'b1, 1'b0);
        idle();
        repeat (2) step();
        n = 0;
        while (a_adv !== 1'b1 && n < 8) begin
            chk(32'(i_adv), 32'h0);
            n++;
            step();
        end
        chk(32'(n), 32'h2);
        repeat (4) step();
        $display("test coprocessor walk done");
        // usage bit clear: exception, no transaction
        usable = 1'b0;
        issue(5'h00, 5'h00, 5'h0c, 1'b0, 1'b1, 1'b0);
        idle();
        chk(32'(exc), 32'h1);
        chk(32'(instr_en), 32'h0);
        step();
        chk(32'(cv), 32'h0);
        usable = 1'b1;
        repeat (4) step();
        $display("test unusable done");
        // reset in mid-run while the align stage waits on a late return
        issue(5'h01, 5'h00, 5'h0e, 1'b0, 1'b1, 1'b0);
        idle();
        repeat (2) step();
        chk(32'(a_adv), 32'h0);
        rst = 1'b1;
        #1;
        chk(32'(a_adv), 32'h1);
        chk(32'(rf_we), 32'h0);
        step();
        rst = 1'b0;
        repeat (2) step();
        chk(32'(i_adv), 32'h1);
        $display("test mid-run reset done");
        // coprocessor branch with prompt and one-cycle-late condition
        for (int j = 0; j < 2; j++) begin
            delay = 2'(j);
            ret_word = 32'(j);
            issue(5'h00, 5'h00, 5'h00, 1'b0, 1'b1, 1'b1);
            idle();
            n = 0;
            while (resolved !== 1'b1 && n < 8) begin
                if (n == 1) chk(32'(cv), 32'h1);
                n++;
                step();
            end
            chk(32'(n), 32'(2 + j));
            chk(32'(i_adv), 32'h1);
            step();
            chk(32'(taken), 32'(j));
            repeat (3) step();
        end
        $display("test coprocessor branch done");
        complete_run();
    end
endmodule // tb_obc_pipe_ctrl
